// ===== rtl/ptc_tick_counter.sv
// prescaled modulo tick counter with avalon-mm register slave
//
// Operation
// - flag sets when count wraps limit to zero
// - writing one clears flag, zero keeps it
// - reset: stopped, zero count, zero limit
// - source field picks one of three clocks
// - changed source clears prescaler and counter
// - interrupt while flag and enable both set
// - zero prescale code keeps everything off
// - divide table when source bit zero clear
// - divide table when source bit zero set
// - changed prescale code clears prescaler and counter
// - count register read only, writes ignored
// - limit write stores and clears both counters
// - zero limit flags every prescaler tick
// - counter climbs to limit then wraps
// - debug halt freezes prescaler and counter
// - keeps running in wait and stop
`timescale 1ns/100ps

module ptc_tick_counter (
	input  wire logic                         core_clk_i,             // core clock, 50 MHz
	input  wire logic                         rst_n_i,                // async reset, active low
	input  wire logic [ptc_pkg::ADDR_W-1:0]   avs_address_i,          // byte address
	input  wire logic                         avs_read_i,             // read request
	input  wire logic                         avs_write_i,            // write request
	input  wire logic [ptc_pkg::DATA_W-1:0]   avs_writedata_i,        // write data
	input  wire logic [3:0]                   avs_byteenable_i,       // byte lanes
	output logic      [ptc_pkg::DATA_W-1:0]   avs_readdata_o,         // read data
	output logic                              avs_waitrequest_o,      // stall request
	input  wire logic                         low_power_osc_clock_i,  // 1 kHz source pin
	input  wire logic                         external_ref_clock_i,   // external source pin
	input  wire logic                         internal_ref_clock_i,   // internal source pin
	input  wire logic                         dbg_halt_i,             // cpu halted in debug
	output logic                              irq_o                   // interrupt and wakeup
);

	////////////////////////////////////////////////////////////////////////////////
	// divide-by lookup for a given source lsb and prescale code
	// code zero yields zero, so the prescaler can never reach its last count;
	// the widest entry of the second table sets the prescaler width

	function automatic logic [ptc_pkg::DIV_W-1:0] ptc_divisor(
		input logic       src_lsb,
		input logic [3:0] ps
	);
		logic [ptc_pkg::DIV_W-1:0] d;
		d = 18'h00000;
		if (!src_lsb) begin
			// binary steps for codes one to seven, decimal steps above
			case (ps)
				4'h1: d = 18'h00008;
				4'h2: d = 18'h00020;
				4'h3: d = 18'h00040;
				4'h4: d = 18'h00080;
				4'h5: d = 18'h00100;
				4'h6: d = 18'h00200;
				4'h7: d = 18'h00400;
				4'h8: d = 18'h00001;
				4'h9: d = 18'h00002;
				4'ha: d = 18'h00004;
				4'hb: d = 18'h0000a;
				4'hc: d = 18'h00010;
				4'hd: d = 18'h00064;
				4'he: d = 18'h001f4;
				4'hf: d = 18'h003e8;
				default: d = 18'h00000;
			endcase
		end else begin
			// slow table when source bit zero is set (external, or internal by code 3), same code layout
			case (ps)
				4'h1: d = 18'h00400;
				4'h2: d = 18'h00800;
				4'h3: d = 18'h01000;
				4'h4: d = 18'h02000;
				4'h5: d = 18'h04000;
				4'h6: d = 18'h08000;
				4'h7: d = 18'h10000;
				4'h8: d = 18'h003e8;
				4'h9: d = 18'h007d0;
				4'ha: d = 18'h01388;
				4'hb: d = 18'h02710;
				4'hc: d = 18'h04e20;
				4'hd: d = 18'h0c350;
				4'he: d = 18'h186a0;
				4'hf: d = 18'h30d40;
				default: d = 18'h00000;
			endcase
		end
		return d;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// registers
	// ctrl_r holds the flag, the source, the enable and the prescale code

	ptc_pkg::ptc_ctrl_t          ctrl_r;        // status and control
	logic [7:0]                  count_r;       // tick count value
	logic [7:0]                  limit_r;       // match limit
	logic [ptc_pkg::DIV_W-1:0]   pre_cnt_r;     // prescaler count
	ptc_pkg::ptc_bus_st_t        bus_st_r;      // bus handshake state
	logic [ptc_pkg::DATA_W-1:0]  rd_data_r;     // captured read data

	ptc_pkg::ptc_ctrl_t          ctrl_nxt;
	logic [7:0]                  count_nxt;
	logic [7:0]                  limit_nxt;
	logic [ptc_pkg::DIV_W-1:0]   pre_cnt_nxt;
	ptc_pkg::ptc_bus_st_t        bus_st_nxt;

	////////////////////////////////////////////////////////////////////////////////
	// source pins are asynchronous: two flops, then a third for edge history
	// the pins come from other clock trees, so only the second flop is read;
	// the history flop resets low like an idle pin, so no false edge
	// follows reset. a source must stay high and low for two core cycles
	// or more, or an edge can slip past unseen

	wire logic [2:0] src_pins;
	wire logic [2:0] src_rise;

	assign src_pins = {internal_ref_clock_i, external_ref_clock_i, low_power_osc_clock_i};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_src_sync
			logic sync1_r;   // first sync stage
			logic sync2_r;   // second sync stage
			logic hist_r;    // last synchronised level

			// rising edge of each synchronised source
			assign src_rise[gi] = sync2_r & ~hist_r;

			always_ff @(posedge core_clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					sync1_r <= 1'b0;
					sync2_r <= 1'b0;
					hist_r  <= 1'b0;
				end else begin
					sync1_r <= src_pins[gi];
					sync2_r <= sync1_r;
					hist_r  <= sync2_r;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// source selection

	logic sel_edge;

	// unselected pins keep synchronising, so a switch sees settled levels
	// pick the edge of the selected source; both 1x codes take internal
	always_comb begin
		case (ctrl_r.source_select)
			ptc_pkg::PTC_SRC_LOW_POWER: sel_edge = src_rise[0];
			ptc_pkg::PTC_SRC_EXTERNAL:  sel_edge = src_rise[1];
			default:                    sel_edge = src_rise[2];
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// bus decode: one wait cycle, then the access completes
	// the first cycle latches read data and arms the handshake, the second
	// completes it; writes act only on the completing edge, so a stalled
	// write never lands twice. only byte lane zero carries a register,
	// the other lanes are ignored

	wire logic                        bus_req;
	wire logic                        bus_done;
	wire logic                        wr_go;
	wire logic                        hit_ctrl;
	wire logic                        hit_count;
	wire logic                        hit_limit;
	wire logic                        ctrl_wr;
	wire logic                        limit_wr;
	wire logic [7:0]                  wbyte;
	wire logic [1:0]                  wr_src;
	wire logic [3:0]                  wr_ps;
	wire logic                        src_chg;
	wire logic                        ps_chg;
	wire logic                        clr_counts;
	logic      [ptc_pkg::DATA_W-1:0]  rd_mux;

	assign bus_req   = avs_read_i | avs_write_i;
	assign bus_done  = bus_req & (bus_st_r == ptc_pkg::PTC_BUS_ACK);
	assign wr_go     = bus_done & avs_write_i & avs_byteenable_i[0];
	assign hit_ctrl  = (avs_address_i == ptc_pkg::OFS_STATUS_CONTROL);
	assign hit_count = (avs_address_i == ptc_pkg::OFS_COUNT);
	assign hit_limit = (avs_address_i == ptc_pkg::OFS_MODULO_LIMIT);
	assign ctrl_wr   = wr_go & hit_ctrl;
	// a write to the count register decodes to nothing
	assign limit_wr  = wr_go & hit_limit;
	assign wbyte     = avs_writedata_i[7:0];
	assign wr_src    = wbyte[ptc_pkg::SRC_HI_BIT:ptc_pkg::SRC_LO_BIT];
	assign wr_ps     = wbyte[ptc_pkg::PS_HI_BIT:ptc_pkg::PS_LO_BIT];

	// only a changed source or prescale field, or any limit write, restarts the counting chain
	assign src_chg    = ctrl_wr & (wr_src != ctrl_r.source_select);
	assign ps_chg     = ctrl_wr & (wr_ps != ctrl_r.prescale_select);
	assign clr_counts = src_chg | ps_chg | limit_wr;

	// read mux, upper bits and unmapped addresses read zero
	// the value is caught in the stalled cycle, so it shows the register
	// one cycle before the completing edge
	always_comb begin
		rd_mux = '0;
		if (hit_ctrl) begin
			rd_mux[7:0] = ctrl_r;
		end else if (hit_count) begin
			rd_mux[7:0] = count_r;
		end else if (hit_limit) begin
			rd_mux[7:0] = limit_r;
		end
	end

	// stall the first cycle of every request
	assign avs_waitrequest_o = bus_req & (bus_st_r == ptc_pkg::PTC_BUS_IDLE);
	assign avs_readdata_o    = rd_data_r;

	// handshake state
	// a request still high in the ack cycle is the one finishing, so the
	// state always drops back to idle and a new request waits a cycle
	always_comb begin
		case (bus_st_r)
			ptc_pkg::PTC_BUS_IDLE: bus_st_nxt = bus_req ? ptc_pkg::PTC_BUS_ACK
			                                            : ptc_pkg::PTC_BUS_IDLE;
			ptc_pkg::PTC_BUS_ACK:  bus_st_nxt = ptc_pkg::PTC_BUS_IDLE;
			default:               bus_st_nxt = ptc_pkg::PTC_BUS_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// prescaler: counts selected edges, ticks once per divide period
	// it counts synchronised source edges, not core clocks, so the divide
	// count is in source periods; div_last is the last count before a tick,
	// and with code zero it wraps to all ones, which is never reached

	wire logic [ptc_pkg::DIV_W-1:0] div_val;
	wire logic [ptc_pkg::DIV_W-1:0] div_last;
	wire logic                      run;
	wire logic                      pre_tick;

	assign div_val  = ptc_divisor(ctrl_r.source_select[0], ctrl_r.prescale_select);
	assign div_last = div_val - 18'h00001;
	// no gating by wait or stop; only debug halt freezes
	assign run      = (ctrl_r.prescale_select != ptc_pkg::PS_OFF) & ~dbg_halt_i;
	assign pre_tick = run & sel_edge & (pre_cnt_r == div_last);

	// a halted prescaler keeps its count, while a clear still applies
	always_comb begin
		pre_cnt_nxt = pre_cnt_r;
		if (clr_counts) begin
			pre_cnt_nxt = '0;
		end else if (ctrl_r.prescale_select == ptc_pkg::PS_OFF) begin
			pre_cnt_nxt = '0;
		end else if (run && sel_edge) begin
			pre_cnt_nxt = pre_tick ? '0 : pre_cnt_r + 18'h00001;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// modulo counter and match

	wire logic match;

	// a tick at the limit wraps to zero; limit zero matches every tick
	assign match = pre_tick & (count_r == limit_r);

	// a clear from a write beats a tick in the same cycle, so a restarted
	// chain always begins from zero
	always_comb begin
		count_nxt = count_r;
		if (clr_counts) begin
			count_nxt = '0;
		end else if (match) begin
			count_nxt = '0;
		end else if (pre_tick) begin
			count_nxt = count_r + 8'h01;
		end
	end

	assign limit_nxt = limit_wr ? wbyte : limit_r;

	////////////////////////////////////////////////////////////////////////////////
	// status and control next value
	// the match set is applied after the write, so an event in the same
	// cycle as a write-one clear is never lost

	always_comb begin
		ctrl_nxt = ctrl_r;
		if (ctrl_wr) begin
			ctrl_nxt.source_select    = wr_src;
			ctrl_nxt.match_irq_enable = wbyte[ptc_pkg::IE_BIT];
			ctrl_nxt.prescale_select  = wr_ps;
			if (wbyte[ptc_pkg::FLAG_BIT]) begin
				ctrl_nxt.match_flag = 1'b0;
			end
		end
		if (match) begin
			ctrl_nxt.match_flag = 1'b1;
		end
	end

	// level interrupt, also the wakeup request in low power states
	// the flag stays set while the enable is off; enabling later raises it
	assign irq_o = ctrl_r.match_flag & ctrl_r.match_irq_enable;

	////////////////////////////////////////////////////////////////////////////////
	// state flops
	// the prescaler resets with the counter, so the first period after
	// reset is a full one

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_r    <= ptc_pkg::CTRL_RST;
			count_r   <= ptc_pkg::COUNT_RST;
			limit_r   <= ptc_pkg::LIMIT_RST;
			pre_cnt_r <= '0;
		end else begin
			ctrl_r    <= ctrl_nxt;
			count_r   <= count_nxt;
			limit_r   <= limit_nxt;
			pre_cnt_r <= pre_cnt_nxt;
		end
	end

	// bus flops: read data caught on the stalled cycle
	// capture only happens when idle, so the value cannot move while the
	// master waits to take it
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bus_st_r  <= ptc_pkg::PTC_BUS_IDLE;
			rd_data_r <= '0;
		end else begin
			bus_st_r <= bus_st_nxt;
			if (avs_read_i && bus_st_r == ptc_pkg::PTC_BUS_IDLE) begin
				rd_data_r <= rd_mux;
			end
		end
	end

endmodule

// ===== rtl/ptc_pkg.sv
// package of constants and types for the prescaled modulo tick counter
package ptc_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// clock and bus layout
	localparam int unsigned CORE_CLK_HZ = 50_000_000;   // core clock rate
	localparam int unsigned ADDR_W      = 4;            // byte address width
	localparam int unsigned DATA_W      = 32;           // bus data width
	localparam int unsigned REG_W       = 8;            // register width
	localparam int unsigned DIV_W       = 18;           // widest divide count

	// byte offsets of the three registers
	localparam logic [3:0] OFS_STATUS_CONTROL = 4'h0;
	localparam logic [3:0] OFS_COUNT          = 4'h4;
	localparam logic [3:0] OFS_MODULO_LIMIT   = 4'h8;

	////////////////////////////////////////////////////////////////////////////////
	// field positions of the status and control register
	localparam int unsigned FLAG_BIT   = 7;  // match flag, write one to clear
	localparam int unsigned SRC_HI_BIT = 6;  // source select msb
	localparam int unsigned SRC_LO_BIT = 5;  // source select lsb
	localparam int unsigned IE_BIT     = 4;  // match interrupt enable
	localparam int unsigned PS_HI_BIT  = 3;  // prescale select msb
	localparam int unsigned PS_LO_BIT  = 0;  // prescale select lsb

	// reset values
	localparam logic [7:0] CTRL_RST  = 8'h00;
	localparam logic [7:0] COUNT_RST = 8'h00;
	localparam logic [7:0] LIMIT_RST = 8'h00;
	localparam logic [3:0] PS_OFF    = 4'h0;   // prescaler stopped

	////////////////////////////////////////////////////////////////////////////////
	// types
	typedef enum logic [1:0] {
		PTC_SRC_LOW_POWER = 2'h0,   // low_power_osc_clock
		PTC_SRC_EXTERNAL  = 2'h1,   // external_ref_clock
		PTC_SRC_INTERNAL  = 2'h2    // internal_ref_clock, 2'h3 also
	} ptc_src_t;

	typedef enum logic {
		PTC_BUS_IDLE = 1'b0,        // no request taken yet
		PTC_BUS_ACK  = 1'b1         // request answered this cycle
	} ptc_bus_st_t;

	// status and control register, laid out msb first
	typedef struct packed {
		logic       match_flag;
		logic [1:0] source_select;
		logic       match_irq_enable;
		logic [3:0] prescale_select;
	} ptc_ctrl_t;

endpackage

// ===== bench/ptc_tick_counter_monitor.sv
// checker of bus timing and interrupt causes for the tick counter
`timescale 1ns/100ps
module ptc_tick_counter_monitor (
	input wire logic        core_clk_i,             // core clock
	input wire logic        rst_n_i,                // reset, active low
	input wire logic [3:0]  avs_address_i,          // byte address
	input wire logic        avs_read_i,             // read request
	input wire logic        avs_write_i,            // write request
	input wire logic [31:0] avs_writedata_i,        // write data
	input wire logic [3:0]  avs_byteenable_i,       // byte lanes
	input wire logic [31:0] avs_readdata_o,         // read data
	input wire logic        avs_waitrequest_o,      // stall
	input wire logic        low_power_osc_clock_i,  // source pin
	input wire logic        external_ref_clock_i,   // source pin
	input wire logic        internal_ref_clock_i,   // source pin
	input wire logic        dbg_halt_i,             // debug halt
	input wire logic        irq_o                   // interrupt
);
	logic       req;
	logic       ctl_wr;
	logic [2:0] pin_q;
	logic [5:0] rise_h;
	////////////////////////////////////////////////////////////////////////////////
	// completed control writes and recent source edges
	assign req    = avs_read_i | avs_write_i;
	assign ctl_wr = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0] & (avs_address_i == 4'h0);
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_q  <= 3'h0;
			rise_h <= 6'h00;
		end else begin
			pin_q  <= {internal_ref_clock_i, external_ref_clock_i, low_power_osc_clock_i};
			rise_h <= {rise_h[4:0], |({internal_ref_clock_i, external_ref_clock_i,
				low_power_osc_clock_i} & ~pin_q)};
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// assertions
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	reset_quiet_a: assert property (
		$rose(rst_n_i) |-> !irq_o && avs_readdata_o == 32'h0) else $error("outputs busy after reset");
	irq_cause_a: assert property (
		$rose(irq_o) |-> $past(ctl_wr) || (|rise_h)) else $error("irq rose without cause");
	w1c_drop_a: assert property (
		ctl_wr && avs_writedata_i[7] && !(|rise_h) |=> !irq_o) else $error("flag not cleared");
	ie_off_a: assert property (
		ctl_wr && !avs_writedata_i[4] |=> !irq_o) else $error("irq with enable clear");
	halt_freeze_a: assert property (
		$rose(irq_o) && $past(dbg_halt_i) |-> $past(ctl_wr)) else $error("counted while halted");
	one_wait_a: assert property (
		req && !$past(req) |-> avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("wait state");
	rdata_hold_a: assert property (
		!$past(avs_read_i) |-> $stable(avs_readdata_o)) else $error("read data moved");
	rdata_upper_a: assert property (
		avs_readdata_o[31:8] == 24'h0) else $error("upper read bits set");
	irq_rise_c: cover property ($rose(irq_o));
	read_done_c: cover property (avs_read_i && !avs_waitrequest_o);
	halt_write_c: cover property (dbg_halt_i && ctl_wr);
endmodule
bind ptc_tick_counter ptc_tick_counter_monitor mon (.core_clk_i, .rst_n_i, .avs_address_i,
	.avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
	.avs_waitrequest_o, .low_power_osc_clock_i, .external_ref_clock_i, .internal_ref_clock_i,
	.dbg_halt_i, .irq_o);

// ===== bench/testbench.sv
// self-checking bench for the tick counter: registers, counting, interrupt
`timescale 1ns/100ps
module testbench;
	logic        core_clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic [3:0]  avs_address_i = 4'h0;
	logic        avs_read_i = 1'b0;
	logic        avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [31:0] avs_readdata_o;
	logic        avs_waitrequest_o;
	logic [2:0]  pins = 3'h0;  // internal, external, low power
	logic        dbg_halt_i = 1'b0;
	logic        irq_o;
	logic [15:0] seed = 16'h04c0;
	logic [3:0]  codes [7] = '{4'h1, 4'h2, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc};
	logic [31:0] q;
	int          mismatches = 0;
	int          samples_checked = 0;
	int          k;
	always #10 core_clk_i = ~core_clk_i;
	ptc_tick_counter dut (.core_clk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
		.avs_writedata_i, .avs_byteenable_i(4'hf), .avs_readdata_o, .avs_waitrequest_o,
		.low_power_osc_clock_i(pins[0]), .external_ref_clock_i(pins[1]),
		.internal_ref_clock_i(pins[2]), .dbg_halt_i, .irq_o);
	////////////////////////////////////////////////////////////////////////////////
	// expectation helpers
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic int div_of(input logic lsb, input logic [3:0] ps);
		int t0 [16] = '{0, 8, 32, 64, 128, 256, 512, 1024, 1, 2, 4, 10, 16, 100, 500, 1000};
		int t1 [16] = '{0, 1024, 2048, 4096, 8192, 16384, 32768, 65536, 1000, 2000, 5000,
			10000, 20000, 50000, 100000, 200000};
		return lsb ? t1[ps] : t0[ps];
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	// bus, pin and compare tasks
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		avs_address_i   <= a;
		avs_writedata_i <= {24'h0, d};
		avs_read_i      <= ~w;
		avs_write_i     <= w;
		// hold until waitrequest is sampled low at a rising edge; the watchdog ends a hang
		do begin
			@(posedge core_clk_i);
		end while (avs_waitrequest_o !== 1'b0);
		q = avs_readdata_o;
		avs_read_i  <= 1'b0;
		avs_write_i <= 1'b0;
	endtask
	task automatic rdc(input string nm, input logic [3:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(nm, {24'h0, e}, q);
	endtask
	task automatic irqc(input logic e);
		@(negedge core_clk_i);
		chk("irq", {31'h0, e}, {31'h0, irq_o});
	endtask
	task automatic tick(input int p, input int n);
		repeat (n) begin
			@(posedge core_clk_i);
			pins[p] <= 1'b1;
			repeat (3) @(posedge core_clk_i);
			pins[p] <= 1'b0;
			repeat (2) @(posedge core_clk_i);
		end
		repeat (5) @(posedge core_clk_i);
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// watchdog and main sequence
	initial begin
		#(40000 * 20);
		mismatches++;
		wrap_up;
	end
	initial begin
		repeat (4) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		rdc("ctrl", 4'h0, 8'h00);
		rdc("count", 4'h4, 8'h00);
		rdc("limit", 4'h8, 8'h00);
		rdc("unmapped", 4'hc, 8'h00);
		for (k = 0; k < 8; k++) begin
			seed = lfsr(seed);
			bus(1'b1, 4'h8, seed[7:0]);
			rdc("limit", 4'h8, seed[7:0]);
			bus(1'b1, 4'h4, seed[15:8]);
			rdc("count", 4'h4, 8'h00);
			bus(1'b1, 4'h0, seed[15:8]);
			rdc("ctrl", 4'h0, {1'b0, seed[14:8]});
		end
		$display("test registers done");
		bus(1'b1, 4'h8, 8'h03);
		bus(1'b1, 4'h0, 8'h18);
		tick(0, 3);
		rdc("count", 4'h4, 8'h03);
		irqc(1'b0);
		tick(0, 1);
		rdc("ctrl", 4'h0, 8'h98);
		irqc(1'b1);
		bus(1'b1, 4'h0, 8'h18);
		rdc("ctrl", 4'h0, 8'h98);
		bus(1'b1, 4'h0, 8'h98);
		rdc("ctrl", 4'h0, 8'h18);
		irqc(1'b0);
		$display("test wrap done");
		tick(1, 2);
		tick(0, 2);
		rdc("count", 4'h4, 8'h02);
		bus(1'b1, 4'h0, 8'h38);
		rdc("count", 4'h4, 8'h00);
		tick(0, 2);
		rdc("count", 4'h4, 8'h00);
		tick(1, div_of(1'b1, 4'h8));
		rdc("count", 4'h4, 8'h01);
		bus(1'b1, 4'h0, 8'h58);
		tick(2, 1);
		rdc("count", 4'h4, 8'h01);
		$display("test source done");
		for (k = 0; k < 7; k++) begin
			bus(1'b1, 4'h0, {4'h1, codes[k]});
			tick(0, div_of(1'b0, codes[k]) - 1);
			rdc("count", 4'h4, 8'h00);
			tick(0, 1);
			rdc("count", 4'h4, 8'h01);
		end
		bus(1'b1, 4'h0, 8'h10);
		tick(0, 2);
		rdc("count", 4'h4, 8'h00);
		$display("test prescale done");
		bus(1'b1, 4'h8, 8'h00);
		bus(1'b1, 4'h0, 8'h18);
		tick(0, 1);
		irqc(1'b1);
		bus(1'b1, 4'h0, 8'h08);
		irqc(1'b0);
		dbg_halt_i <= 1'b1;
		bus(1'b1, 4'h0, 8'h18);
		irqc(1'b1);
		bus(1'b1, 4'h0, 8'h98);
		tick(0, 2);
		irqc(1'b0);
		dbg_halt_i <= 1'b0;
		tick(0, 1);
		irqc(1'b1);
		// pin edge and write-one clear land on the same core edge
		@(posedge core_clk_i);
		pins[0] <= 1'b1;
		bus(1'b1, 4'h0, 8'h98);
		pins[0] <= 1'b0;
		irqc(1'b1);
		bus(1'b1, 4'h8, 8'h03);
		tick(0, 2);
		dbg_halt_i <= 1'b1;
		tick(0, 2);
		rdc("count", 4'h4, 8'h02);
		dbg_halt_i <= 1'b0;
		tick(0, 1);
		rdc("count", 4'h4, 8'h03);
		$display("test halt done");
		wrap_up;
	end
endmodule
